// file: logic/asa_top.sv
// Asynchronous serial adapter: bus registers, transmitter, receiver, modem lines
//
// How it works
// RULE1: Data drivers enabled only during selected reads
// RULE2: Selected when both highs high, low low
// RULE3: Read drives read register; write stores
// RULE4: Enable strobe gates buffers and times transfers
// RULE5: Register pick chooses data or control pair
// RULE6: Interrupt low while enabled cause present
// RULE7: New transmit bit on transmit clock fall
// RULE8: Receiver samples on receive clock rise
// RULE9: Ratio 1, 16 or 64 from divide field
// RULE10: Ratio one needs externally aligned receive clock
// RULE11: 16x and 64x align to start bit
// RULE12: Clear-to-send high hides transmit empty
// RULE13: Request-to-send follows transmit control only
// RULE14: Carrier lost holds receiver initialised
// RULE15: Carrier loss rise interrupts when enabled
// RULE16: Status bits: full, empty, carrier, cts, errors, irq
// RULE17: Control bits: divide, word, transmit, interrupt
// RULE18: Characters travel least significant bit first
// RULE19: Unused received upper bits read zero
// RULE20: Unused transmit upper bits are ignored
// RULE21: Four byte registers, two read, two write
// RULE22: Pick low status/control, high data
// RULE23: Divide codes 1,16,64; code three resets
// RULE24: Word field sets length, parity, stops
// RULE25: Transmit control sets send request, interrupt, break
// RULE26: Idle mark, start low, data, parity, stops
`default_nettype none
`include "asa_defs.svh"

module asa_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_high_a,
    input wire logic chip_select_high_b,
    input wire logic chip_select_low,
    input wire logic register_pick,
    input wire logic read_write,
    input wire logic enable_strobe,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe,
    input wire logic interrupt_out_n_i,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe,
    input wire logic transmit_bit_clock,
    input wire logic receive_bit_clock,
    input wire logic serial_in_line,
    output logic serial_out_line,
    input wire logic clear_to_send_n,
    output logic request_to_send_out_n,
    input wire logic carrier_lost_in
);
    import asa_pkg::*;

    // Bus side
    logic e_prev_reg;
    logic acc_sel_reg;
    logic acc_rp_reg;
    logic acc_rw_reg;
    logic [7:0] acc_wd_reg;
    logic [7:0] line_config_reg;
    logic [7:0] data_o_reg;
    logic data_oe_reg;
    logic selected;
    logic commit;
    logic wr_cfg;
    logic wr_tx;
    logic rd_status;
    logic rd_data;

    // Configuration fields
    logic [1:0] div_sel;
    logic [2:0] word_sel;
    logic [1:0] tx_ctl;
    logic rxi;
    logic mreset;

    // Status state
    logic [7:0] rx_char_buffer_reg;
    logic rxfl_reg;
    logic ovfl_pend_reg;
    logic ovfl_vis_reg;
    logic fm_reg;
    logic pb_reg;
    logic cls_latch_reg;
    logic cls_armed_reg;
    logic cls_prev_reg;
    logic irq_active_reg;
    logic irq_n_reg;
    logic [7:0] line_flags;
    logic txem;
    logic irq_cause;

    // Transmit path
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic tx_load;
    asa_tx_state_e tx_state_reg;
    logic [7:0] tx_data_reg;
    logic [3:0] tx_idx_reg;
    logic tx_stop2_reg;
    logic tx_line_reg;
    logic serial_out_reg;
    logic rts_n_reg;
    logic tclk_prev_reg;
    logic tx_tick;
    logic tx_strobe;

    // Receive path
    asa_rx_state_e rx_state_reg;
    logic [7:0] rx_shift_reg;
    logic [3:0] rx_idx_reg;
    logic rx_par_bad_reg;
    logic rclk_prev_reg;
    logic rx_tick;
    logic rx_strobe;
    logic rx_hold;
    logic rx_done;
    logic rx_fm;
    logic rx_lose;

    assign div_sel = line_config_reg[`ASA_CF_DIV_HI:`ASA_CF_DIV_LO]; // RULE17
    assign word_sel = line_config_reg[`ASA_CF_WS_HI:`ASA_CF_WS_LO];
    assign tx_ctl = line_config_reg[`ASA_CF_TC_HI:`ASA_CF_TC_LO];
    assign rxi = line_config_reg[`ASA_CF_RXI];
    assign mreset = div_sel == `ASA_DIV_MRESET; // RULE23

    // Bus decode; access takes effect on the falling edge of the strobe
    assign selected = chip_select_high_a && chip_select_high_b && !chip_select_low; // RULE2
    assign commit = e_prev_reg && !enable_strobe && acc_sel_reg; // RULE4
    assign wr_cfg = commit && !acc_rw_reg && !acc_rp_reg; // RULE22
    assign wr_tx = commit && !acc_rw_reg && acc_rp_reg; // RULE5
    assign rd_status = commit && acc_rw_reg && !acc_rp_reg; // RULE22
    assign rd_data = commit && acc_rw_reg && acc_rp_reg; // RULE5

    // Address and data are held from the last cycle the strobe was high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            e_prev_reg <= 1'b0;
            acc_sel_reg <= 1'b0;
            acc_rp_reg <= 1'b0;
            acc_rw_reg <= 1'b1;
            acc_wd_reg <= 8'h00;
        end else begin
            e_prev_reg <= enable_strobe;
            if (enable_strobe) begin
                acc_sel_reg <= selected;
                acc_rp_reg <= register_pick;
                acc_rw_reg <= read_write;
                acc_wd_reg <= data_i;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_config_reg <= `ASA_CFG_RESET;
        end else if (wr_cfg) begin
            line_config_reg <= acc_wd_reg; // RULE21
        end
    end

    // Read drivers only during a selected read while the strobe is high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_oe_reg <= 1'b0;
            data_o_reg <= 8'h00;
        end else begin
            data_oe_reg <= selected && read_write && enable_strobe; // RULE1
            data_o_reg <= register_pick ? rx_char_buffer_reg : line_flags; // RULE3
        end
    end

    assign txem = fifo_in_ready && !clear_to_send_n && !mreset; // RULE12

    always_comb begin
        line_flags = 8'h00;
        line_flags[`ASA_ST_RXFL] = rxfl_reg && !carrier_lost_in; // RULE16
        line_flags[`ASA_ST_TXEM] = txem;
        line_flags[`ASA_ST_CLS] = cls_latch_reg || carrier_lost_in;
        line_flags[`ASA_ST_CTS] = clear_to_send_n;
        line_flags[`ASA_ST_FM] = fm_reg;
        line_flags[`ASA_ST_OVFL] = ovfl_vis_reg;
        line_flags[`ASA_ST_PB] = pb_reg;
        line_flags[`ASA_ST_IRQ] = irq_active_reg;
    end

    assign irq_cause = (rxi && (rxfl_reg || cls_latch_reg)) // RULE15
        || ((tx_ctl == `ASA_TC_RTS_INT) && txem); // RULE25

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_active_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else begin
            irq_active_reg <= irq_cause; // RULE6
            irq_n_reg <= !irq_cause;
        end
    end

    // Receive status; a character finishing in the read cycle wins unless an overrun is pending
    assign rx_lose = rxfl_reg && !(rd_data && !ovfl_pend_reg);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxfl_reg <= 1'b0;
            ovfl_pend_reg <= 1'b0;
            ovfl_vis_reg <= 1'b0;
            fm_reg <= 1'b0;
            pb_reg <= 1'b0;
            rx_char_buffer_reg <= 8'h00;
        end else if (mreset) begin
            rxfl_reg <= 1'b0; // RULE23
            ovfl_pend_reg <= 1'b0;
            ovfl_vis_reg <= 1'b0;
            fm_reg <= 1'b0;
            pb_reg <= 1'b0;
        end else begin
            if (rd_data) begin
                if (ovfl_pend_reg) begin
                    // Overrun surfaces only after the good character is read
                    ovfl_vis_reg <= 1'b1;
                    ovfl_pend_reg <= 1'b0;
                end else begin
                    rxfl_reg <= 1'b0;
                    ovfl_vis_reg <= 1'b0;
                end
            end
            if (rx_done) begin
                if (rx_lose) begin
                    ovfl_pend_reg <= 1'b1;
                end else begin
                    rx_char_buffer_reg <= rx_shift_reg; // RULE19
                    fm_reg <= rx_fm;
                    pb_reg <= rx_par_bad_reg;
                    rxfl_reg <= 1'b1;
                end
            end
        end
    end

    // Carrier loss flag: cleared by a status read followed by a data read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cls_prev_reg <= 1'b0;
            cls_latch_reg <= 1'b0;
            cls_armed_reg <= 1'b0;
        end else begin
            cls_prev_reg <= carrier_lost_in;
            if (mreset) begin
                cls_latch_reg <= 1'b0;
                cls_armed_reg <= 1'b0;
            end else if (rd_status && cls_latch_reg) begin
                cls_armed_reg <= 1'b1;
            end else if (rd_data && cls_armed_reg) begin
                cls_latch_reg <= 1'b0;
                cls_armed_reg <= 1'b0;
            end
            if (carrier_lost_in && !cls_prev_reg) begin
                cls_latch_reg <= 1'b1; // RULE15
            end
        end
    end

    // Writes while full are dropped; software watches the empty flag
    asa_fifo #(
        .WIDTH(`ASA_TX_FIFO_WIDTH),
        .DEPTH(`ASA_TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(mreset),
        .in_valid(wr_tx),
        .in_ready(fifo_in_ready),
        .in_data(acc_wd_reg),
        .out_valid(fifo_out_valid),
        .out_ready(tx_load),
        .out_data(fifo_out_data)
    );

    assign tx_tick = tclk_prev_reg && !transmit_bit_clock; // RULE7

    asa_baud_count u_tx_count (
        .clk(clk),
        .rst(rst),
        .tick(tx_tick),
        .clear(mreset || (tx_state_reg == ASA_TX_IDLE)),
        .half(1'b0),
        .div_sel(div_sel), // RULE9
        .strobe(tx_strobe)
    );

    assign tx_load = !mreset && fifo_out_valid
        && (((tx_state_reg == ASA_TX_IDLE) && tx_tick)
        || ((tx_state_reg == ASA_TX_STOP) && tx_strobe && !tx_stop2_reg));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tclk_prev_reg <= 1'b0;
            tx_state_reg <= ASA_TX_IDLE;
            tx_data_reg <= 8'h00;
            tx_idx_reg <= 4'h0;
            tx_stop2_reg <= 1'b0;
            tx_line_reg <= 1'b1;
        end else begin
            tclk_prev_reg <= transmit_bit_clock;
            if (mreset) begin
                tx_state_reg <= ASA_TX_IDLE;
                tx_line_reg <= 1'b1;
            end else if (tx_load) begin
                tx_data_reg <= fifo_out_data;
                tx_line_reg <= 1'b0; // RULE26
                tx_state_reg <= ASA_TX_START;
            end else if (tx_strobe) begin
                unique case (tx_state_reg)
                    ASA_TX_START: begin
                        tx_line_reg <= tx_data_reg[0]; // RULE18
                        tx_idx_reg <= 4'h1;
                        tx_state_reg <= ASA_TX_DATA;
                    end
                    ASA_TX_DATA: begin
                        if (tx_idx_reg == asa_data_bits(word_sel)) begin // RULE20
                            if (asa_has_parity(word_sel)) begin // RULE24
                                tx_line_reg <= asa_parity(tx_data_reg, word_sel);
                                tx_state_reg <= ASA_TX_PAR;
                            end else begin
                                tx_line_reg <= 1'b1;
                                tx_stop2_reg <= asa_two_stops(word_sel);
                                tx_state_reg <= ASA_TX_STOP;
                            end
                        end else begin
                            tx_line_reg <= tx_data_reg[tx_idx_reg[2:0]];
                            tx_idx_reg <= tx_idx_reg + 4'h1;
                        end
                    end
                    ASA_TX_PAR: begin
                        tx_line_reg <= 1'b1;
                        tx_stop2_reg <= asa_two_stops(word_sel);
                        tx_state_reg <= ASA_TX_STOP;
                    end
                    ASA_TX_STOP: begin
                        if (tx_stop2_reg) begin
                            tx_stop2_reg <= 1'b0;
                        end else begin
                            tx_state_reg <= ASA_TX_IDLE;
                        end
                    end
                    default: begin
                        tx_line_reg <= 1'b1;
                        tx_state_reg <= ASA_TX_IDLE;
                    end
                endcase
            end
        end
    end

    // Break forces space; request-to-send comes from the control field alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_out_reg <= 1'b1;
            rts_n_reg <= 1'b1;
        end else begin
            serial_out_reg <= (tx_ctl == `ASA_TC_BREAK) ? 1'b0 : tx_line_reg; // RULE25
            rts_n_reg <= tx_ctl == `ASA_TC_NORTS; // RULE13
        end
    end

    // Receiver
    assign rx_hold = mreset || carrier_lost_in; // RULE14
    assign rx_tick = !rclk_prev_reg && receive_bit_clock; // RULE8
    assign rx_done = !rx_hold && rx_strobe && (rx_state_reg == ASA_RX_STOP);
    assign rx_fm = !serial_in_line;

    asa_baud_count u_rx_count (
        .clk(clk),
        .rst(rst),
        .tick(rx_tick),
        .clear(rx_hold || (rx_state_reg == ASA_RX_IDLE)),
        .half(rx_state_reg == ASA_RX_START), // RULE11
        .div_sel(div_sel), // RULE9
        .strobe(rx_strobe)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rclk_prev_reg <= 1'b1;
            rx_state_reg <= ASA_RX_IDLE;
            rx_shift_reg <= 8'h00;
            rx_idx_reg <= 4'h0;
            rx_par_bad_reg <= 1'b0;
        end else begin
            rclk_prev_reg <= receive_bit_clock;
            if (rx_hold) begin
                rx_state_reg <= ASA_RX_IDLE;
                rx_par_bad_reg <= 1'b0;
            end else if ((rx_state_reg == ASA_RX_IDLE) && rx_tick && !serial_in_line) begin
                rx_shift_reg <= 8'h00;
                rx_idx_reg <= 4'h0;
                rx_par_bad_reg <= 1'b0;
                // At ratio one the clock is trusted to be aligned already
                rx_state_reg <= (div_sel == `ASA_DIV_1) ? ASA_RX_DATA : ASA_RX_START; // RULE10
            end else if (rx_strobe) begin
                unique case (rx_state_reg)
                    ASA_RX_IDLE: begin
                        rx_state_reg <= ASA_RX_IDLE;
                    end
                    ASA_RX_START: begin
                        // Glitch shorter than half a bit is not a start
                        rx_state_reg <= serial_in_line ? ASA_RX_IDLE : ASA_RX_DATA; // RULE11
                    end
                    ASA_RX_DATA: begin
                        rx_shift_reg[rx_idx_reg[2:0]] <= serial_in_line; // RULE18
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == asa_data_bits(word_sel) - 4'h1) begin
                            rx_state_reg <= asa_has_parity(word_sel) ? ASA_RX_PAR
                                : ASA_RX_STOP; // RULE24
                        end
                    end
                    ASA_RX_PAR: begin
                        rx_par_bad_reg <= serial_in_line != asa_parity(rx_shift_reg, word_sel);
                        rx_state_reg <= ASA_RX_STOP;
                    end
                    ASA_RX_STOP: begin
                        rx_state_reg <= ASA_RX_IDLE;
                    end
                    default: begin
                        rx_state_reg <= ASA_RX_IDLE;
                    end
                endcase
            end
        end
    end

    assign data_o = data_o_reg;
    assign data_oe = data_oe_reg;
    assign interrupt_out_n_o = irq_n_reg;
    assign interrupt_out_n_oe = irq_active_reg; // RULE6
    assign serial_out_line = serial_out_reg;
    assign request_to_send_out_n = rts_n_reg;

endmodule // asa_top

`default_nettype wire

// file: logic/asa_defs.svh
// Constants of the serial adapter: field positions, codes, reset values, ratios
`ifndef ASA_DEFS_SVH
`define ASA_DEFS_SVH

// Status register bit positions
`define ASA_ST_RXFL 0
`define ASA_ST_TXEM 1
`define ASA_ST_CLS 2
`define ASA_ST_CTS 3
`define ASA_ST_FM 4
`define ASA_ST_OVFL 5
`define ASA_ST_PB 6
`define ASA_ST_IRQ 7

// Control register field positions
`define ASA_CF_DIV_LO 0
`define ASA_CF_DIV_HI 1
`define ASA_CF_WS_LO 2
`define ASA_CF_WS_HI 4
`define ASA_CF_TC_LO 5
`define ASA_CF_TC_HI 6
`define ASA_CF_RXI 7

// Divide select codes
`define ASA_DIV_1 2'h0
`define ASA_DIV_16 2'h1
`define ASA_DIV_64 2'h2
`define ASA_DIV_MRESET 2'h3

// Bit clock ratios
`define ASA_RATIO_16 16
`define ASA_RATIO_64 64

// Word select codes that differ in stop bits or parity
`define ASA_WS_7E2 3'h0
`define ASA_WS_7O2 3'h1
`define ASA_WS_8N2 3'h4
`define ASA_WS_8N1 3'h5

// Transmit control codes
`define ASA_TC_RTS_NOINT 2'h0
`define ASA_TC_RTS_INT 2'h1
`define ASA_TC_NORTS 2'h2
`define ASA_TC_BREAK 2'h3

// Reset value: held in master reset until software selects a ratio
`define ASA_CFG_RESET 8'h03

`define ASA_TX_FIFO_DEPTH 32
`define ASA_TX_FIFO_WIDTH 8

`endif

// file: logic/asa_pkg.sv
// Types and character format decoders of the serial adapter
`default_nettype none
`include "asa_defs.svh"

package asa_pkg;

    typedef enum logic [2:0] {
        ASA_TX_IDLE = 3'b000,
        ASA_TX_START = 3'b001,
        ASA_TX_DATA = 3'b010,
        ASA_TX_PAR = 3'b011,
        ASA_TX_STOP = 3'b100
    } asa_tx_state_e;

    typedef enum logic [2:0] {
        ASA_RX_IDLE = 3'b000,
        ASA_RX_START = 3'b001,
        ASA_RX_DATA = 3'b010,
        ASA_RX_PAR = 3'b011,
        ASA_RX_STOP = 3'b100
    } asa_rx_state_e;

    function automatic logic [3:0] asa_data_bits(input logic [2:0] ws);
        asa_data_bits = ws[2] ? 4'h8 : 4'h7;
    endfunction

    function automatic logic asa_has_parity(input logic [2:0] ws);
        asa_has_parity = (ws != `ASA_WS_8N2) && (ws != `ASA_WS_8N1);
    endfunction

    function automatic logic asa_two_stops(input logic [2:0] ws);
        asa_two_stops = (ws == `ASA_WS_7E2) || (ws == `ASA_WS_7O2) || (ws == `ASA_WS_8N2);
    endfunction

    // Parity bit for the active character length; low word bit selects odd
    function automatic logic asa_parity(input logic [7:0] d, input logic [2:0] ws);
        logic [7:0] m;
        m = ws[2] ? d : {1'b0, d[6:0]};
        asa_parity = (^m) ^ ws[0];
    endfunction

endpackage : asa_pkg

`default_nettype wire

// file: logic/asa_fifo.sv
// Transmit character FIFO with valid/ready on both sides
`default_nettype none
`include "asa_defs.svh"

module asa_fifo #(
    parameter int WIDTH = `ASA_TX_FIFO_WIDTH,
    parameter int DEPTH = `ASA_TX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import asa_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg != (AW + 1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Depth is a power of two so pointers wrap by themselves
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            if (push && !pop) begin
                count_reg <= count_reg + (AW + 1)'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - (AW + 1)'(1);
            end
        end
    end

endmodule // asa_fifo

`default_nettype wire

// file: logic/asa_baud_count.sv
// Bit period counter over bit clock edges, for the 1, 16 and 64 ratios
`default_nettype none
`include "asa_defs.svh"

module asa_baud_count (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic clear,
    input wire logic half,
    input wire logic [1:0] div_sel,
    output logic strobe
);
    import asa_pkg::*;

    localparam logic [5:0] LIM_16 = 6'(`ASA_RATIO_16 - 1);
    localparam logic [5:0] LIM_64 = 6'(`ASA_RATIO_64 - 1);
    localparam logic [5:0] HALF_16 = 6'(`ASA_RATIO_16 / 2 - 1);
    localparam logic [5:0] HALF_64 = 6'(`ASA_RATIO_64 / 2 - 1);

    logic [5:0] cnt_reg;
    logic [5:0] limit;

    always_comb begin
        unique case (div_sel)
            `ASA_DIV_16: limit = half ? HALF_16 : LIM_16;
            `ASA_DIV_64: limit = half ? HALF_64 : LIM_64;
            `ASA_DIV_1, `ASA_DIV_MRESET: limit = 6'h00;
        endcase
    end

    assign strobe = tick && !clear && (cnt_reg == limit);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 6'h00;
        end else if (clear || strobe) begin
            cnt_reg <= 6'h00;
        end else if (tick) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

endmodule // asa_baud_count

`default_nettype wire

// file: verif/asa_modem.sv
// Modem model: one free running bit clock for both directions, line looped back
`default_nettype none
module asa_modem (
    output logic bclk,
    input wire logic txd,
    output wire logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    // Same clock feeds the receiver, so looped data is already aligned to it
    assign rxd = txd;
    initial begin
        bclk = 1'h1;
        forever #1200 bclk = ~bclk;
    end
endmodule // asa_modem
`default_nettype wire

// file: verif/asa_top_monitor.sv
// Port checker of the serial adapter and its bind
`default_nettype none
module asa_top_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic chip_select_high_a,
    input wire logic chip_select_high_b,
    input wire logic chip_select_low,
    input wire logic register_pick,
    input wire logic read_write,
    input wire logic enable_strobe,
    input wire logic [7:0] data_o,
    input wire logic data_oe,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe,
    input wire logic transmit_bit_clock,
    input wire logic serial_out_line,
    input wire logic clear_to_send_n,
    input wire logic request_to_send_out_n,
    input wire logic carrier_lost_in
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [3:0] tf_reg;
    wire logic sel = chip_select_high_a && chip_select_high_b && !chip_select_low;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) tf_reg <= 4'h0;
        else tf_reg <= {tf_reg[2:0], $fell(transmit_bit_clock)};
    end
    property p_oe; data_oe |-> $past(sel && read_write && enable_strobe); endproperty
    a_oe: assert property (p_oe) else $error("stray drive");
    property p_on; sel && read_write && enable_strobe |=> data_oe; endproperty
    a_on: assert property (p_on) else $error("no drive");
    property p_off; $fell(enable_strobe) |=> !data_oe; endproperty
    a_off: assert property (p_off) else $error("drive held");
    property p_irq; interrupt_out_n_oe |-> !interrupt_out_n_o; endproperty
    a_irq: assert property (p_irq) else $error("irq level");
    property p_cts; data_oe && !$past(register_pick) && $past(clear_to_send_n)
        |-> !data_o[1] && data_o[3]; endproperty
    a_cts: assert property (p_cts) else $error("empty shown");
    property p_cls; data_oe && !$past(register_pick) && $past(carrier_lost_in)
        |-> data_o[2] && !data_o[0]; endproperty
    a_cls: assert property (p_cls) else $error("rx not held");
    property p_tx; $changed(serial_out_line) |-> |tf_reg; endproperty
    a_tx: assert property (p_tx) else $error("bit off edge");
    property p_rts; $changed(request_to_send_out_n) |-> $past(enable_strobe, 2)
        || $past(enable_strobe, 3) || $past(rst, 2); endproperty
    a_rts: assert property (p_rts) else $error("rts moved");
endmodule // asa_top_monitor
bind asa_top asa_top_monitor mon_u (.*);
`default_nettype wire

// file: verif/async_serial_interface_adapter_test.sv
// Bench: bus transfers, looped back frames, modem lines
`default_nettype none
module async_serial_interface_adapter_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, chip_select_high_a, chip_select_high_b, chip_select_low;
    logic register_pick, read_write, enable_strobe, clear_to_send_n, carrier_lost_in;
    logic [7:0] data_i, q;
    wire logic [7:0] data_o;
    wire logic data_oe, interrupt_out_n_o, interrupt_out_n_oe, serial_out_line;
    wire logic request_to_send_out_n, transmit_bit_clock, serial_in_line;
    wire logic receive_bit_clock = transmit_bit_clock;
    wire logic interrupt_out_n_i = interrupt_out_n_oe ? 1'h0 : 1'h1;
    int n_errors, n_tests;
    asa_top dut_u (.*);
    asa_modem mdm_u (.bclk(transmit_bit_clock), .txd(serial_out_line), .rxd(serial_in_line));
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic s, input logic rp, input logic rw, input logic [7:0] d);
        @(negedge clk);
        chip_select_high_a = s;
        register_pick = rp;
        read_write = rw;
        data_i = d;
        enable_strobe = 1'h1;
        repeat (2) @(negedge clk);
        q = data_o;
        enable_strobe = 1'h0;
        repeat (2) @(negedge clk);
    endtask
    task automatic st(input logic [7:0] e);
        bus(1'h1, 1'h0, 1'h1, 8'h00);
        chk(q, e);
    endtask
    // Polls status until a character lands, then reads it
    task automatic rx(input logic [7:0] e);
        q = 8'h00;
        repeat (1000) if (!q[0]) bus(1'h1, 1'h0, 1'h1, 8'h00);
        chk(q, 8'h03);
        bus(1'h1, 1'h1, 1'h1, 8'h00);
        chk(q, e);
    endtask
    task automatic t_fmt();
        bus(1'h1, 1'h0, 1'h0, 8'h14);
        st(8'h02);
        chk({7'h00, request_to_send_out_n}, 8'h00);
        bus(1'h1, 1'h1, 1'h0, 8'ha5);
        rx(8'ha5);
        bus(1'h1, 1'h0, 1'h0, 8'h08);
        bus(1'h1, 1'h1, 1'h0, 8'hd3);
        rx(8'h53);
        $display("format test done");
    endtask
    task automatic t_div();
        bus(1'h1, 1'h0, 1'h0, 8'h15);
        bus(1'h1, 1'h1, 1'h0, 8'h3c);
        rx(8'h3c);
        $display("divide test done");
    endtask
    task automatic t_mdm();
        clear_to_send_n = 1'h1;
        st(8'h08);
        clear_to_send_n = 1'h0;
        bus(1'h0, 1'h0, 1'h0, 8'h54);
        chk({7'h00, request_to_send_out_n}, 8'h00);
        bus(1'h1, 1'h0, 1'h0, 8'h54);
        chk({7'h00, request_to_send_out_n}, 8'h01);
        bus(1'h1, 1'h0, 1'h0, 8'h94);
        carrier_lost_in = 1'h1;
        st(8'h86);
        chk({7'h00, interrupt_out_n_i}, 8'h00);
        carrier_lost_in = 1'h0;
        bus(1'h1, 1'h1, 1'h1, 8'h00);
        chk({7'h00, interrupt_out_n_i}, 8'h01);
        bus(1'h1, 1'h0, 1'h0, 8'h03);
        st(8'h00);
        $display("modem test done");
    endtask
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        #5000000;
        n_errors++;
        conclude();
    end
    initial begin
        n_errors = 0;
        n_tests = 0;
        rst = 1'h1;
        {chip_select_high_a, chip_select_high_b, chip_select_low} = 3'h2;
        {register_pick, read_write, enable_strobe} = 3'h0;
        {clear_to_send_n, carrier_lost_in} = 2'h0;
        data_i = 8'h00;
        repeat (12) @(negedge clk);
        rst = 1'h0;
        t_fmt();
        t_div();
        t_mdm();
        conclude();
    end
endmodule // async_serial_interface_adapter_test
`default_nettype wire
